/* File: inc/rgp_pkg.sv */
// Constants and types shared by the external PHY port and its transmit FIFO.
// Assumes a single 200 MHz core clock; all pin timing is derived from it.
package rgp_pkg;

  // Core clock period.
  localparam int CLK_PERIOD_NS = 5;

  // Half periods of the generated clocks.
  localparam int REF_HALF_NS = 20;
  localparam int TX100_HALF_NS = 20;
  localparam int TX10_HALF_NS = 200;
  localparam int MDC_HALF_NS = 200;

  // Half periods counted in core clock cycles.
  localparam logic [5:0] REF_HALF_CYC = 6'(REF_HALF_NS / CLK_PERIOD_NS);
  localparam logic [5:0] TX100_HALF_CYC = 6'(TX100_HALF_NS / CLK_PERIOD_NS);
  localparam logic [5:0] TX10_HALF_CYC = 6'(TX10_HALF_NS / CLK_PERIOD_NS);
  localparam logic [5:0] MDC_HALF_CYC = 6'(MDC_HALF_NS / CLK_PERIOD_NS);

  // Transmit FIFO depth.
  localparam int TX_FIFO_DEPTH = 8;

  // Bit positions in the synchronised pin vector.
  localparam int SB_RXC = 0;
  localparam int SB_RXCTL = 1;
  localparam int SB_RXD = 2;
  localparam int SB_GIG = 6;
  localparam int SB_IRQ = 7;
  localparam int SB_DPX = 8;
  localparam int SB_MDIO = 9;
  localparam int SYNC_W = 10;
  // Idle levels: interrupt and management data high, all else low.
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h280;

  // Management frame layout: preamble, start, opcode, addresses, turnaround, data.
  localparam logic [6:0] MD_BITS = 7'h40;
  localparam logic [6:0] MD_TA_BIT = 7'h2e;
  localparam logic [6:0] MD_DATA_BIT = 7'h30;
  localparam logic [31:0] MD_PREAMBLE = 32'hffffffff;
  localparam logic [1:0] MD_START = 2'h1;
  localparam logic [1:0] MD_OP_RD = 2'h2;
  localparam logic [1:0] MD_OP_WR = 2'h1;
  localparam logic [1:0] MD_TA_WR = 2'h2;

  // Link speed selection.
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} rgp_speed_t;

  // Management engine states.
  typedef enum logic {MD_IDLE, MD_RUN} rgp_md_state_t;

  // One byte of frame data with its error mark.
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } rgp_byte_t;

  // One received byte as presented to the user.
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } rgp_rx_t;

  // Management transaction request.
  typedef struct packed {
    logic rd;
    logic [4:0] phy;
    logic [4:0] regad;
    logic [15:0] wdata;
  } rgp_mdio_cmd_t;

endpackage

/* File: design/rgp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module rgp_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count.
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage is written without reset.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // rgp_fifo

/* File: design/rgp_port.sv */
// MAC-side pin logic toward an external gigabit PHY over RGMII, with management master.
// Assumes the PHY adds the clock-to-data skew; all pins are sampled by the 200 MHz core clock.
`timescale 1ns/1ps
// Overview of operation
// RL1: Transmit clock runs at 125, 25 or 2.5 MHz by selected speed.
// RL2: PHY supplies receive clock at the same speed-dependent rates.
// RL3: Transmit control line carries enable on rise, enable xor error on fall.
// RL4: Receive control line decoded into data valid and receive error.
// RL5: Outgoing bytes leave as nibbles on four transmit data lines.
// RL6: Incoming nibbles on four receive lines are captured at receive clock edges.
// RL7: A continuous 25 MHz reference clock is driven to the PHY.
// RL8: In gigabit mode the transmit clock follows the PHY 125 MHz input.
// RL9: Duplex input high means full duplex, low means half duplex.
// RL10: Management data line is released whenever no transaction runs.
// RL11: Block is management master and drives the management clock.
// RL12: Active-low PHY reset output holds the PHY in reset while low.
// RL13: Active-low PHY interrupt input is reported as a one-cycle event.
// RL14: Gigabit uses both edges, low nibble on rise, high nibble on fall.
module rgp_port (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Mode control.
  input wire rgp_pkg::rgp_speed_t speed_i,
  input wire logic phy_reset_req_i,
  // Transmit byte stream.
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire rgp_pkg::rgp_byte_t tx_byte_i,
  // Receive byte stream.
  output rgp_pkg::rgp_rx_t rx_o,
  output logic rx_eof_o,
  // Management requests.
  input wire logic md_valid_i,
  output logic md_ready_o,
  input wire rgp_pkg::rgp_mdio_cmd_t md_cmd_i,
  output logic md_done_o,
  output logic [15:0] md_rdata_o,
  // Status toward the MAC.
  output logic full_duplex_o,
  output logic phy_irq_evt_o,
  // RGMII pins.
  output logic phy_txc_o,
  output logic phy_tx_ctl_o,
  output logic [3:0] phy_txd_o,
  input wire logic phy_rxc_i,
  input wire logic phy_rx_ctl_i,
  input wire logic [3:0] phy_rxd_i,
  // Side-band pins.
  output logic phy_ref_clock_out_o,
  input wire logic phy_gig_clock_in_i,
  input wire logic duplex_i,
  input wire logic phy_irq_n_i,
  output logic phy_rst_out_n_o,
  // Management pins.
  output logic mdc_o,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o
);
  logic [rgp_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, stab_q, stab_d, chg;
  logic gig, gig_edge, tx_tick, tx_rise, tx_fall, fifo_v, fifo_pop, tx_en_q, tx_err_q, tx_nib_q;
  logic rx_rise, rx_fall, rx_dv_q, rx_nib_q, rx_err_acc_q, rx_ctl_s, ref_q, mdc_rise, mdc_fall;
  logic [3:0] rx_lo_q, rxd_s;
  logic [5:0] tx_cnt_q, ref_cnt_q, mdc_cnt_q, tx_half, mdc_hold_q;
  logic [6:0] md_cnt_q;
  logic [63:0] md_sh_q;
  logic md_rd_q, mdc_last_q;
  rgp_pkg::rgp_byte_t fifo_byte, tx_cur_q;
  rgp_pkg::rgp_md_state_t md_state_q;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  assign stab_d = (s2_q & s3_q) | (stab_q & (s2_q ^ s3_q));
  assign chg = stab_d ^ stab_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= rgp_pkg::SYNC_RST;
      s2_q <= rgp_pkg::SYNC_RST;
      s3_q <= rgp_pkg::SYNC_RST;
      stab_q <= rgp_pkg::SYNC_RST;
    end else begin
      s1_q <= {mdio_i, duplex_i, phy_irq_n_i, phy_gig_clock_in_i, phy_rxd_i, phy_rx_ctl_i, phy_rxc_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stab_d;
    end
  end

  // Status pins: duplex level and interrupt assertion event.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      full_duplex_o <= 1'b0;
      phy_irq_evt_o <= 1'b0;
    end else begin
      full_duplex_o <= stab_d[rgp_pkg::SB_DPX]; // RL9
      phy_irq_evt_o <= chg[rgp_pkg::SB_IRQ] && !stab_d[rgp_pkg::SB_IRQ]; // RL13
    end
  end

  // PHY reset is held low through core reset and on request.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phy_rst_out_n_o <= 1'b0;
    end else begin
      phy_rst_out_n_o <= !phy_reset_req_i; // RL12
    end
  end

  // Free-running 25 MHz reference clock divider.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_q <= '0;
      ref_q <= 1'b0;
    end else if (ref_cnt_q == rgp_pkg::REF_HALF_CYC - 6'h1) begin
      ref_cnt_q <= '0;
      ref_q <= !ref_q; // RL7
    end else begin
      ref_cnt_q <= ref_cnt_q + 6'h1;
    end
  end
  assign phy_ref_clock_out_o = ref_q;

  // Transmit FIFO between the user stream and the pin sequencer.
  rgp_fifo #(
    .W($bits(rgp_pkg::rgp_byte_t)),
    .DEPTH(rgp_pkg::TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_byte_i),
    .out_valid_o(fifo_v),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_byte)
  );

  // Transmit clock ticks: PHY gigabit clock edges, otherwise a core divider.
  assign gig = (speed_i == rgp_pkg::SPD_1000);
  assign gig_edge = chg[rgp_pkg::SB_GIG];
  assign tx_half = (speed_i == rgp_pkg::SPD_100) ? rgp_pkg::TX100_HALF_CYC : rgp_pkg::TX10_HALF_CYC;
  assign tx_tick = gig ? gig_edge : (tx_cnt_q >= tx_half - 6'h1); // RL8
  assign tx_rise = tx_tick && !phy_txc_o;
  assign tx_fall = tx_tick && phy_txc_o;
  assign fifo_pop = tx_rise && fifo_v && (gig || !tx_nib_q);

  // Transmit clock generation.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_q <= '0;
      phy_txc_o <= 1'b0;
    end else begin
      tx_cnt_q <= (tx_tick || gig) ? 6'h0 : tx_cnt_q + 6'h1;
      if (tx_tick) begin
        phy_txc_o <= !phy_txc_o; // RL1
      end
    end
  end

  // Transmit sequencer: nibbles and control on the pins.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cur_q <= '0;
      tx_en_q <= 1'b0;
      tx_err_q <= 1'b0;
      tx_nib_q <= 1'b0;
      phy_txd_o <= '0;
      phy_tx_ctl_o <= 1'b0;
    end else if (tx_rise) begin
      if (!gig && tx_nib_q) begin
        phy_txd_o <= tx_cur_q.data[7:4]; // RL5
        phy_tx_ctl_o <= 1'b1;
        tx_nib_q <= 1'b0;
      end else if (fifo_v) begin
        tx_cur_q <= fifo_byte;
        tx_en_q <= 1'b1;
        tx_err_q <= fifo_byte.err;
        phy_txd_o <= fifo_byte.data[3:0]; // RL14
        phy_tx_ctl_o <= 1'b1; // RL3
        tx_nib_q <= !gig;
      end else begin
        tx_en_q <= 1'b0;
        tx_err_q <= 1'b0;
        tx_nib_q <= 1'b0;
        phy_txd_o <= '0;
        phy_tx_ctl_o <= 1'b0;
      end
    end else if (tx_fall) begin
      phy_tx_ctl_o <= tx_en_q ^ tx_err_q; // RL3
      if (gig) begin
        phy_txd_o <= tx_cur_q.data[7:4]; // RL14
      end
    end
  end

  // Receive pins as seen after synchronisation.
  assign rx_rise = chg[rgp_pkg::SB_RXC] && stab_d[rgp_pkg::SB_RXC];
  assign rx_fall = chg[rgp_pkg::SB_RXC] && !stab_d[rgp_pkg::SB_RXC];
  assign rx_ctl_s = stab_d[rgp_pkg::SB_RXCTL];
  assign rxd_s = stab_d[rgp_pkg::SB_RXD +: 4];

  // Receive decoder: data valid on rise, valid xor error on fall.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_dv_q <= 1'b0;
      rx_nib_q <= 1'b0;
      rx_err_acc_q <= 1'b0;
      rx_lo_q <= '0;
      rx_o <= '0;
      rx_eof_o <= 1'b0;
    end else begin
      rx_o.valid <= 1'b0;
      rx_eof_o <= 1'b0;
      if (rx_rise) begin
        rx_dv_q <= rx_ctl_s; // RL4
        rx_eof_o <= rx_dv_q && !rx_ctl_s;
        if (gig || !rx_ctl_s || !rx_nib_q) begin
          rx_lo_q <= rxd_s; // RL6
          rx_nib_q <= !gig && rx_ctl_s;
        end else begin
          rx_o.valid <= 1'b1;
          rx_o.err <= rx_err_acc_q;
          rx_o.data <= {rxd_s, rx_lo_q}; // RL6
          rx_nib_q <= 1'b0;
          rx_err_acc_q <= 1'b0;
        end
        if (!rx_ctl_s) begin
          rx_err_acc_q <= 1'b0;
        end
      end else if (rx_fall && rx_dv_q) begin
        if (gig) begin
          rx_o.valid <= 1'b1;
          rx_o.err <= rx_ctl_s ^ rx_dv_q; // RL4
          rx_o.data <= {rxd_s, rx_lo_q}; // RL14
        end else begin
          rx_err_acc_q <= rx_err_acc_q | (rx_ctl_s ^ rx_dv_q); // RL4
        end
      end
    end
  end

  // Management clock, free running as the master clock.
  assign mdc_rise = (mdc_cnt_q == rgp_pkg::MDC_HALF_CYC - 6'h1) && !mdc_o;
  assign mdc_fall = (mdc_cnt_q == rgp_pkg::MDC_HALF_CYC - 6'h1) && mdc_o;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_cnt_q <= '0;
      mdc_o <= 1'b0;
    end else if (mdc_rise || mdc_fall) begin
      mdc_cnt_q <= '0;
      mdc_o <= !mdc_o; // RL11
    end else begin
      mdc_cnt_q <= mdc_cnt_q + 6'h1;
    end
  end

  // Management frame engine; bits change after falling MDC, sampled at rising.
  // The line is released one cycle after the last rising MDC so the PHY keeps hold time.
  assign md_ready_o = (md_state_q == rgp_pkg::MD_IDLE);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      md_state_q <= rgp_pkg::MD_IDLE;
      md_cnt_q <= '0;
      md_sh_q <= '0;
      md_rd_q <= 1'b0;
      md_done_o <= 1'b0;
      md_rdata_o <= '0;
      mdio_o <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end else begin
      md_done_o <= 1'b0;
      case (md_state_q)
        rgp_pkg::MD_IDLE: begin
          mdio_oe_n_o <= 1'b1; // RL10
          if (md_valid_i) begin
            md_state_q <= rgp_pkg::MD_RUN;
            md_cnt_q <= '0;
            md_rd_q <= md_cmd_i.rd;
            md_sh_q <= {rgp_pkg::MD_PREAMBLE, rgp_pkg::MD_START,
                        md_cmd_i.rd ? rgp_pkg::MD_OP_RD : rgp_pkg::MD_OP_WR,
                        md_cmd_i.phy, md_cmd_i.regad, rgp_pkg::MD_TA_WR, md_cmd_i.wdata};
          end
        end
        rgp_pkg::MD_RUN: begin
          if (md_cnt_q > rgp_pkg::MD_BITS) begin
            md_state_q <= rgp_pkg::MD_IDLE;
            md_done_o <= 1'b1;
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1; // RL10
          end else if (mdc_fall && md_cnt_q != rgp_pkg::MD_BITS) begin
            mdio_o <= md_sh_q[63];
            mdio_oe_n_o <= md_rd_q && (md_cnt_q >= rgp_pkg::MD_TA_BIT); // RL10
            md_sh_q <= {md_sh_q[62:0], 1'b1};
            md_cnt_q <= md_cnt_q + 7'h1;
          end else if (mdc_rise) begin
            if (md_rd_q && md_cnt_q > rgp_pkg::MD_DATA_BIT) begin
              md_rdata_o <= {md_rdata_o[14:0], stab_d[rgp_pkg::SB_MDIO]};
            end
            if (md_cnt_q == rgp_pkg::MD_BITS) begin
              md_cnt_q <= md_cnt_q + 7'h1;
            end
          end
        end
        default: begin
          md_state_q <= rgp_pkg::MD_IDLE;
        end
      endcase
    end
  end

  // Cycles the management clock has held its level, for the half-period check.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_last_q <= 1'b0;
      mdc_hold_q <= '0;
    end else begin
      mdc_last_q <= mdc_o;
      mdc_hold_q <= (mdc_o != mdc_last_q) ? 6'h1 : mdc_hold_q + 6'h1;
    end
  end

  // Checks on pin behaviour.
  property p_ref_period;
    @(posedge clk_i) disable iff (rst_i) $rose(phy_ref_clock_out_o) |-> ##8 $rose(phy_ref_clock_out_o);
  endproperty
  a_ref_period: assert property (p_ref_period) else $error("Reference clock period is not 40 ns."); // RL7
  property p_tx100_half;
    @(posedge clk_i) disable iff (rst_i)
      (speed_i == rgp_pkg::SPD_100)[*6] ##0 $rose(phy_txc_o) ##1 (speed_i == rgp_pkg::SPD_100)[*4] |-> $fell(phy_txc_o);
  endproperty
  a_tx100_half: assert property (p_tx100_half) else $error("Transmit clock high time wrong at 100 Mb/s."); // RL1
  property p_gig_src;
    @(posedge clk_i) disable iff (rst_i) (gig && $past(gig) && $changed(phy_txc_o)) |-> $past(gig_edge);
  endproperty
  a_gig_src: assert property (p_gig_src) else $error("Gigabit transmit clock moved without input edge."); // RL8
  property p_tx_start;
    @(posedge clk_i) disable iff (rst_i)
      $past(fifo_pop) |-> phy_tx_ctl_o && phy_txc_o && phy_txd_o == $past(fifo_byte.data[3:0]);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("Low nibble or enable missing on transmit clock rise."); // RL5
  property p_tx_fall_ctl;
    @(posedge clk_i) disable iff (rst_i) $fell(phy_txc_o) |-> phy_tx_ctl_o == (tx_en_q ^ tx_err_q);
  endproperty
  a_tx_fall_ctl: assert property (p_tx_fall_ctl) else $error("Transmit control wrong at falling edge."); // RL3
  property p_tx_gig_hi;
    @(posedge clk_i) disable iff (rst_i) (gig && $fell(phy_txc_o) && tx_en_q) |-> phy_txd_o == tx_cur_q.data[7:4];
  endproperty
  a_tx_gig_hi: assert property (p_tx_gig_hi) else $error("High nibble not sent on gigabit fall."); // RL14
  property p_rx_gig_byte;
    @(posedge clk_i) disable iff (rst_i)
      (gig && rx_fall && rx_dv_q) |=> rx_o.valid && rx_o.data[7:4] == $past(rxd_s) && rx_o.err == !$past(rx_ctl_s);
  endproperty
  a_rx_gig_byte: assert property (p_rx_gig_byte) else $error("Gigabit receive byte or error decoded wrong."); // RL4
  property p_md_release;
    @(posedge clk_i) disable iff (rst_i) (md_state_q == rgp_pkg::MD_IDLE) |-> mdio_oe_n_o;
  endproperty
  a_md_release: assert property (p_md_release) else $error("Management data driven while idle."); // RL10
  property p_mdc_half;
    @(posedge clk_i) disable iff (rst_i) (mdc_hold_q <= 6'h28) && (!$changed(mdc_o) || mdc_hold_q == 6'h28);
  endproperty
  a_mdc_half: assert property (p_mdc_half) else $error("Management clock half period is not 40 cycles."); // RL11
  property p_phy_rst;
    @(posedge clk_i) disable iff (rst_i) phy_reset_req_i |=> !phy_rst_out_n_o ##1 ($past(phy_reset_req_i) || phy_rst_out_n_o);
  endproperty
  a_phy_rst: assert property (p_phy_rst) else $error("PHY reset output does not follow request."); // RL12
  property p_irq_evt;
    @(posedge clk_i) disable iff (rst_i) $fell(stab_q[rgp_pkg::SB_IRQ]) |-> phy_irq_evt_o;
  endproperty
  a_irq_evt: assert property (p_irq_evt) else $error("PHY interrupt assertion not reported."); // RL13
  property p_duplex;
    @(posedge clk_i) disable iff (rst_i) $changed(stab_q[rgp_pkg::SB_DPX]) |-> full_duplex_o == stab_q[rgp_pkg::SB_DPX];
  endproperty
  a_duplex: assert property (p_duplex) else $error("Duplex status does not follow the pin."); // RL9
  c_tx_byte: cover property (@(posedge clk_i) disable iff (rst_i) fifo_pop ##[1:20] tx_fall);
  c_rx_byte: cover property (@(posedge clk_i) disable iff (rst_i) rx_o.valid ##[1:200] rx_eof_o);
  c_md_read: cover property (@(posedge clk_i) disable iff (rst_i) md_done_o && md_rd_q);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) phy_irq_evt_o);
endmodule // rgp_port

/* File: testbench/rgp_phy_model.sv */
// Behavioural external PHY: gigabit clock, receive frames, management slave.
// Assumes the bench calls send_byte and end_frame and resolves the data line.
`timescale 1ns/1ps
module rgp_phy_model (
  // Receive pins toward the port.
  output logic rxc_o,
  output logic rx_ctl_o,
  output logic [3:0] rxd_o,
  output logic gig_clk_o,
  // Management pins.
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_oe_n_i,
  output logic m_oe_o,
  output logic m_bit_o
);
  logic [63:0] frame;
  logic [6:0] idx;
  logic rd_f;
  logic [15:0] rd_word;
  // Idle receive pins with the clock standing still.
  initial begin
    rxc_o = 1'b0;
    rx_ctl_o = 1'b0;
    rxd_o = 4'h5;
    idx = 7'h00;
    rd_f = 1'b0;
    m_oe_o = 1'b0;
    m_bit_o = 1'b1;
    rd_word = 16'hc3a5;
    gig_clk_o = 1'b0;
    forever #32 gig_clk_o = ~gig_clk_o;
  end
  // One receive clock edge, data set half a phase ahead.
  task automatic edge_at(input logic lvl, input logic ctl, input logic [3:0] d);
    rxd_o = d;
    rx_ctl_o = ctl;
    #16 rxc_o = lvl;
    #16;
  endtask
  // One byte; gigabit carries both nibbles in one clock period.
  task automatic send_byte(input logic [8:0] b, input logic gig);
    edge_at(1'b1, 1'b1, b[3:0]);
    if (gig) begin
      edge_at(1'b0, ~b[8], b[7:4]);
    end else begin
      edge_at(1'b0, ~b[8], ~b[3:0]);
      edge_at(1'b1, 1'b1, b[7:4]);
      edge_at(1'b0, ~b[8], ~b[7:4]);
    end
  endtask
  // Drop data valid, then let the clock stand still.
  task automatic end_frame;
    edge_at(1'b1, 1'b0, ~rxd_o);
    edge_at(1'b0, 1'b0, ~rxd_o);
  endtask
  // Capture management bits at the rising clock once a frame starts.
  always @(posedge mdc_i) begin
    if (idx != 7'h00 || !mdio_oe_n_i) begin
      frame <= {frame[62:0], mdio_i};
      idx <= (idx == 7'h3f) ? 7'h00 : idx + 7'h01;
      if (idx == 7'h24) rd_f <= (frame[1:0] == 2'h2);
    end
  end
  // Answer reads from the second turnaround bit on; the pull-up holds the line otherwise.
  always @(negedge mdc_i) begin
    m_oe_o <= rd_f && idx >= 7'h2f;
    m_bit_o <= (idx == 7'h2f) ? 1'b0 : rd_word[7'h3f - idx];
  end
endmodule // rgp_phy_model

/* File: testbench/tb_rgp_port.sv */
// Self-checking bench of the PHY port: clocks, status, transmit, receive, management.
// Assumes rgp_pkg, the design and the PHY model are compiled first.
`timescale 1ns/1ps
module tb_rgp_port;
  logic clk_i, rst_i, phy_reset_req_i, tx_valid_i, md_valid_i, duplex_i, phy_irq_n_i;
  rgp_pkg::rgp_speed_t speed_i;
  rgp_pkg::rgp_byte_t tx_byte_i;
  rgp_pkg::rgp_rx_t rx_o;
  rgp_pkg::rgp_mdio_cmd_t md_cmd_i;
  logic tx_ready_o, rx_eof_o, md_ready_o, md_done_o, full_duplex_o, phy_irq_evt_o, phy_txc_o;
  logic phy_tx_ctl_o, phy_rxc_i, phy_rx_ctl_i, phy_ref_clock_out_o, phy_gig_clock_in_i;
  logic phy_rst_out_n_o, mdc_o, mdio_o, mdio_oe_n_o, m_oe, m_bit;
  logic [15:0] md_rdata_o;
  logic [3:0] phy_txd_o, phy_rxd_i;
  tri1 mdio_w;
  int miscompares, cmp_count, eofs, irqs;
  logic [8:0] rxq[$];
  // Data line resolved from both drivers and the pull-up.
  assign mdio_w = mdio_oe_n_o ? 1'bz : mdio_o;
  assign mdio_w = m_oe ? m_bit : 1'bz;
  rgp_port u_rgp_port (.clk_i(clk_i), .rst_i(rst_i), .speed_i(speed_i), .phy_reset_req_i(phy_reset_req_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_byte_i(tx_byte_i), .rx_o(rx_o), .rx_eof_o(rx_eof_o),
    .md_valid_i(md_valid_i), .md_ready_o(md_ready_o), .md_cmd_i(md_cmd_i), .md_done_o(md_done_o),
    .md_rdata_o(md_rdata_o), .full_duplex_o(full_duplex_o), .phy_irq_evt_o(phy_irq_evt_o),
    .phy_txc_o(phy_txc_o), .phy_tx_ctl_o(phy_tx_ctl_o), .phy_txd_o(phy_txd_o), .phy_rxc_i(phy_rxc_i),
    .phy_rx_ctl_i(phy_rx_ctl_i), .phy_rxd_i(phy_rxd_i), .phy_ref_clock_out_o(phy_ref_clock_out_o),
    .phy_gig_clock_in_i(phy_gig_clock_in_i), .duplex_i(duplex_i), .phy_irq_n_i(phy_irq_n_i),
    .phy_rst_out_n_o(phy_rst_out_n_o), .mdc_o(mdc_o), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe_n_o(mdio_oe_n_o));
  rgp_phy_model u_rgp_phy_model (.rxc_o(phy_rxc_i), .rx_ctl_o(phy_rx_ctl_i), .rxd_o(phy_rxd_i),
    .gig_clk_o(phy_gig_clock_in_i), .mdc_i(mdc_o), .mdio_i(mdio_w), .mdio_oe_n_i(mdio_oe_n_o),
    .m_oe_o(m_oe), .m_bit_o(m_bit));
  // Core clock, 5 ns period.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Collect one-cycle pulses midway between edges.
  always @(negedge clk_i) begin
    if (rx_o.valid === 1'b1) rxq.push_back({rx_o.err, rx_o.data});
    if (rx_eof_o === 1'b1) eofs++;
    if (phy_irq_evt_o === 1'b1) irqs++;
  end
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [8:0] exp_b(input int k);
    return {k == 2, 8'(8'h11 + k * 37)};
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_clocks;
    realtime t0;
    @(posedge phy_ref_clock_out_o);
    t0 = $realtime;
    @(posedge phy_ref_clock_out_o);
    chk("ref_period", 40, int'($realtime - t0));
    @(posedge mdc_o);
    t0 = $realtime;
    @(posedge mdc_o);
    chk("mdc_period", 400, int'($realtime - t0));
    $display("clocks done");
  endtask
  task automatic t_status;
    tick;
    duplex_i = 1'b1;
    repeat (10) tick;
    chk("full_duplex", 1, full_duplex_o);
    duplex_i = 1'b0;
    repeat (10) tick;
    chk("half_duplex", 0, full_duplex_o);
    irqs = 0;
    phy_irq_n_i = 1'b0;
    repeat (10) tick;
    phy_irq_n_i = 1'b1;
    repeat (10) tick;
    chk("irq_events", 1, irqs);
    phy_reset_req_i = 1'b1;
    repeat (2) tick;
    chk("phy_rst_on", 0, phy_rst_out_n_o);
    phy_reset_req_i = 1'b0;
    repeat (2) tick;
    chk("phy_rst_off", 1, phy_rst_out_n_o);
    $display("status done");
  endtask
  // Push n bytes while decoding them from the pins.
  task automatic t_tx(input rgp_pkg::rgp_speed_t sp, input int n, input int per_exp);
    logic [8:0] got;
    realtime t0, tp, per;
    int lows, w;
    lows = 0;
    tick;
    speed_i = sp;
    fork
      begin
        for (int k = 0; k < n; k++) begin
          tx_valid_i = 1'b1;
          tx_byte_i = exp_b(k);
          while (tx_ready_o !== 1'b1) begin
            lows++;
            tick;
          end
          tick;
        end
        tx_valid_i = 1'b0;
      end
      for (int k = 0; k < n; k++) begin
        w = 0;
        do begin
          @(posedge phy_txc_o);
          #1;
          w++;
        end while (phy_tx_ctl_o !== 1'b1 && w < 400);
        t0 = $realtime;
        per = (k > 0) ? t0 - tp : per_exp;
        tp = t0;
        got[3:0] = phy_txd_o;
        @(negedge phy_txc_o);
        #1;
        got[8] = ~phy_tx_ctl_o;
        got[7:4] = phy_txd_o;
        if (sp != rgp_pkg::SPD_1000) begin
          @(posedge phy_txc_o);
          #1;
          per = $realtime - t0;
          got[7:4] = phy_txd_o;
        end
        chk("tx_byte", exp_b(k), got);
        chk("txc_period", 1, per > per_exp - 6 && per < per_exp + 6);
      end
    join
    if (sp == rgp_pkg::SPD_10) chk("tx_refused", 1, lows > 0);
    $display("transmit done");
  endtask
  task automatic t_rx(input rgp_pkg::rgp_speed_t sp);
    tick;
    speed_i = sp;
    rxq.delete();
    eofs = 0;
    for (int k = 0; k < 3; k++) u_rgp_phy_model.send_byte(exp_b(k), sp == rgp_pkg::SPD_1000);
    u_rgp_phy_model.end_frame();
    repeat (20) tick;
    chk("rx_count", 3, rxq.size());
    for (int k = 0; k < rxq.size(); k++) chk("rx_byte", exp_b(k), rxq[k]);
    chk("rx_eof", 1, eofs);
    $display("receive done");
  endtask
  task automatic t_md(input rgp_pkg::rgp_mdio_cmd_t c);
    int n;
    tick;
    md_cmd_i = c;
    md_valid_i = 1'b1;
    while (md_ready_o !== 1'b1) tick;
    tick;
    md_valid_i = 1'b0;
    chk("md_busy", 0, md_ready_o);
    n = 0;
    while (md_done_o !== 1'b1 && n < 6000) begin
      @(negedge clk_i);
      n++;
    end
    chk("md_done", 1, md_done_o);
    chk("md_head", {32'hffffffff, 2'h1, c.rd ? 2'h2 : 2'h1, c.phy, c.regad},
      u_rgp_phy_model.frame[63:18]);
    chk("md_turn", 2'h2, u_rgp_phy_model.frame[17:16]);
    chk("md_data", c.rd ? 16'hc3a5 : c.wdata, u_rgp_phy_model.frame[15:0]);
    if (c.rd) chk("md_rdata", 16'hc3a5, md_rdata_o);
    tick;
    chk("md_release", 1, mdio_oe_n_o);
    $display("management done");
  endtask
  // Main sequence.
  initial begin
    rst_i = 1'b1;
    phy_reset_req_i = 1'b0;
    tx_valid_i = 1'b0;
    md_valid_i = 1'b0;
    duplex_i = 1'b0;
    phy_irq_n_i = 1'b1;
    speed_i = rgp_pkg::SPD_100;
    tx_byte_i = '0;
    md_cmd_i = '0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("rst_phy_n", 0, phy_rst_out_n_o);
    chk("rst_mdio_rel", 1, mdio_oe_n_o);
    rst_i = 1'b0;
    t_clocks();
    t_status();
    t_tx(rgp_pkg::SPD_10, 10, 400);
    t_tx(rgp_pkg::SPD_100, 3, 40);
    t_tx(rgp_pkg::SPD_1000, 3, 64);
    t_rx(rgp_pkg::SPD_1000);
    t_rx(rgp_pkg::SPD_100);
    t_rx(rgp_pkg::SPD_10);
    t_md({1'b0, 5'h1b, 5'h04, 16'h5a3c});
    t_md({1'b1, 5'h02, 5'h1f, 16'h0000});
    wrap_up();
  end
  // Watchdog against a hung handshake.
  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end
endmodule // tb_rgp_port
